// ---- verilog/compat_map_defs.svh ----
`ifndef COMPAT_MAP_DEFS_SVH
`define COMPAT_MAP_DEFS_SVH

// Data-space addresses
`define IO_LOW_BASE 16'h0020
`define IO_LOW_TOP 16'h005F
`define EXT_IO_BASE 16'h0060
`define EXT_IO_TOP 16'h00FF
// Low I/O index to data-space offset
`define IO_DATA_OFFSET 16'h0020
// Extended window map
`define PCMSK_LO_ADDR 16'h006B
`define PCMSK_HI_ADDR 16'h006C
`define TMR2_FIRST_ADDR 16'h0080
`define TMR2_LAST_ADDR 16'h008B
`define TMR2_FLAG_ADDR 16'h007C
`define TMR2_MASK_ADDR 16'h007D
`define CLKPR_ADDR 16'h0061
// Legacy and extended vector counts
`define VEC_COUNT_LEGACY 8'h14
`define VEC_COUNT_FULL 8'h1C
// Fuse sample delay after reset release
`define FUSE_SETTLE_CYCLES 4'h2

`endif

// ---- verilog/compat_map_pkg.sv ----
package compat_map_pkg;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_RAM,
    TGT_LOW_IO,
    TGT_EXT_IO,
    TGT_EXT_RAM
  } target_t;

  typedef struct packed {
    logic valid;
    logic is_io_instr;
    logic write;
    logic [15:0] addr;
  } cpu_req_t;

  typedef struct packed {
    logic ext_io_sel;
    logic low_io_sel;
    logic ram_sel;
    logic [15:0] addr;
    logic write;
  } decode_t;

  typedef struct packed {
    logic ext_vectors_en;
    logic wdt_timed_seq_en;
    logic rx_double_buf_en;
    logic pin_change_en;
    logic second_timer_en;
  } feature_t;

endpackage

// ---- verilog/fuse_latch.sv ----
`timescale 1ns/1ps
`include "compat_map_defs.svh"

// Captures the fuse once after reset release and holds it until next reset
module fuse_latch (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic fuse_pin,
  output logic fuse_r,
  output logic fuse_valid_r
);
  logic sync1_r;
  logic sync2_r;
  logic [3:0] settle_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= fuse_pin;
      sync2_r <= sync1_r;
    end
  end

  // Decode must never change while the program runs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      settle_r <= 4'h0;
      fuse_r <= 1'b0;
      fuse_valid_r <= 1'b0;
    end else if (ce && !fuse_valid_r) begin
      if (settle_r == `FUSE_SETTLE_CYCLES) begin
        fuse_r <= sync2_r;
        fuse_valid_r <= 1'b1;
      end else begin
        settle_r <= settle_r + 4'h1;
      end
    end
  end

  held_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(fuse_valid_r) && fuse_valid_r |-> $stable(fuse_r))
    else $error("fuse changed after capture");
endmodule

// ---- verilog/legacy_compat_io_map.sv ----
`timescale 1ns/1ps
`include "compat_map_defs.svh"

module legacy_compat_io_map
  import compat_map_pkg::*;
#(
  parameter logic [15:0] SERIAL0_BAUD_HIGH_ADDR = 16'h0040,
  parameter logic [15:0] SERIAL1_BAUD_HIGH_ADDR = 16'h005C
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic legacy_compat_fuse,
  input wire cpu_req_t cpu_req,
  output decode_t dec_r,
  output target_t target_r,
  output feature_t feature_r,
  output logic [7:0] vector_count_r,
  output logic serial0_baud_high_sel_r,
  output logic serial1_baud_high_sel_r,
  output logic pin_change_reg_sel_r,
  output logic second_wide_timer_sel_r,
  output logic first_wide_timer_only_r,
  output logic fuse_valid_r,
  output logic unmapped_r
);
  logic fuse_r;
  logic fuse_ok;
  logic in_low;
  logic in_ext;
  logic [15:0] data_addr;
  target_t tgt_nxt;
  logic pcm_hit;
  logic t2_hit;

  fuse_latch u_fuse (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .fuse_pin(legacy_compat_fuse),
    .fuse_r(fuse_r),
    .fuse_valid_r(fuse_ok)
  );

  // In/out carry a 6-bit I/O index; loads/stores carry a data address
  always_comb begin
    data_addr = cpu_req.is_io_instr ? (cpu_req.addr & 16'h003F) + `IO_DATA_OFFSET
                                    : cpu_req.addr;
    in_low = data_addr >= `IO_LOW_BASE && data_addr <= `IO_LOW_TOP;
    in_ext = !cpu_req.is_io_instr && data_addr >= `EXT_IO_BASE
             && data_addr <= `EXT_IO_TOP;
    pcm_hit = data_addr == `PCMSK_LO_ADDR || data_addr == `PCMSK_HI_ADDR;
    t2_hit = (data_addr >= `TMR2_FIRST_ADDR && data_addr <= `TMR2_LAST_ADDR)
             || data_addr == `TMR2_FLAG_ADDR || data_addr == `TMR2_MASK_ADDR;
    tgt_nxt = TGT_NONE;
    if (!cpu_req.valid || !fuse_ok) begin
      tgt_nxt = TGT_NONE;
    end else if (cpu_req.is_io_instr) begin
      tgt_nxt = TGT_LOW_IO;
    end else if (in_low) begin
      tgt_nxt = TGT_LOW_IO;
    end else if (in_ext) begin
      tgt_nxt = fuse_r ? TGT_EXT_RAM : TGT_EXT_IO;
    end else begin
      tgt_nxt = TGT_RAM;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_r <= TGT_NONE;
      dec_r <= '0;
      unmapped_r <= 1'b0;
    end else if (ce) begin
      target_r <= tgt_nxt;
      dec_r.ext_io_sel <= tgt_nxt == TGT_EXT_IO;
      dec_r.low_io_sel <= tgt_nxt == TGT_LOW_IO;
      dec_r.ram_sel <= tgt_nxt == TGT_RAM || tgt_nxt == TGT_EXT_RAM;
      dec_r.addr <= data_addr;
      dec_r.write <= cpu_req.write;
      // Requests before fuse capture are dropped so decode never flips mid-run
      unmapped_r <= cpu_req.valid && !fuse_ok;
    end
  end

  // Feature gating follows the captured fuse only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      feature_r <= '0;
      vector_count_r <= `VEC_COUNT_LEGACY;
      fuse_valid_r <= 1'b0;
      first_wide_timer_only_r <= 1'b0;
    end else if (ce) begin
      fuse_valid_r <= fuse_ok;
      feature_r.ext_vectors_en <= fuse_ok && !fuse_r;
      vector_count_r <= (fuse_ok && !fuse_r) ? `VEC_COUNT_FULL : `VEC_COUNT_LEGACY;
      feature_r.wdt_timed_seq_en <= fuse_ok && !fuse_r;
      feature_r.rx_double_buf_en <= fuse_ok && !fuse_r;
      feature_r.pin_change_en <= fuse_ok && !fuse_r;
      feature_r.second_timer_en <= fuse_ok && !fuse_r;
      first_wide_timer_only_r <= fuse_ok && fuse_r;
    end
  end

  // Peripheral selects inside the windows
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serial0_baud_high_sel_r <= 1'b0;
      serial1_baud_high_sel_r <= 1'b0;
      pin_change_reg_sel_r <= 1'b0;
      second_wide_timer_sel_r <= 1'b0;
    end else if (ce) begin
      serial0_baud_high_sel_r <= tgt_nxt == TGT_LOW_IO
                                 && data_addr == SERIAL0_BAUD_HIGH_ADDR;
      serial1_baud_high_sel_r <= tgt_nxt == TGT_LOW_IO
                                 && data_addr == SERIAL1_BAUD_HIGH_ADDR;
      pin_change_reg_sel_r <= tgt_nxt == TGT_EXT_IO && pcm_hit;
      second_wide_timer_sel_r <= tgt_nxt == TGT_EXT_IO && t2_hit;
    end
  end

  io_instr_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && cpu_req.is_io_instr |=> target_r == TGT_LOW_IO)
    else $error("in/out reached a non-low target");
  io_not_ext_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && cpu_req.is_io_instr |=> !dec_r.ext_io_sel && !dec_r.ram_sel)
    else $error("in/out reached the extended window");
  ext_io_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && !fuse_r && in_ext
      |=> dec_r.ext_io_sel && target_r == TGT_EXT_IO)
    else $error("extended window not I/O in full mode");
  low_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && !cpu_req.is_io_instr && in_low
      |=> dec_r.low_io_sel && !dec_r.ram_sel)
    else $error("low I/O address not decoded as I/O");
  io_offset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && cpu_req.is_io_instr
      |=> dec_r.addr == {10'h000, $past(cpu_req.addr[5:0])} + `IO_DATA_OFFSET)
    else $error("in/out index not offset into data space");
  ext_ram_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && fuse_ok && fuse_r && in_ext && cpu_req.valid |=> dec_r.ram_sel && !dec_r.ext_io_sel)
    else $error("extended window not RAM in legacy mode");
  ram_above_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && !cpu_req.is_io_instr && data_addr > `EXT_IO_TOP
      |=> target_r == TGT_RAM && dec_r.ram_sel)
    else $error("address above the window not RAM");
  vec_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && fuse_ok && fuse_r |=> vector_count_r == `VEC_COUNT_LEGACY)
    else $error("extended vectors in legacy mode");
  vec_full_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && fuse_ok && !fuse_r |=> vector_count_r == `VEC_COUNT_FULL && feature_r.ext_vectors_en)
    else $error("extended vectors missing in full mode");
  features_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && fuse_ok && !fuse_r |=> feature_r == 5'h1F && !first_wide_timer_only_r)
    else $error("feature missing in full mode");
  wdt_seq_a: assert property (@(posedge mclk) disable iff (!rst_n)
      fuse_valid_r && fuse_r |-> !feature_r.wdt_timed_seq_en)
    else $error("timed sequence enforced in legacy mode");
  rx_buf_a: assert property (@(posedge mclk) disable iff (!rst_n)
      feature_r.rx_double_buf_en |-> fuse_valid_r && !fuse_r)
    else $error("double buffer on in legacy mode");
  rx_single_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && fuse_ok && fuse_r |=> !feature_r.rx_double_buf_en)
    else $error("double buffer kept in legacy mode");
  pcint_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pin_change_reg_sel_r |-> !fuse_r)
    else $error("pin-change register reached in legacy mode");
  pcint_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
      feature_r.pin_change_en |-> fuse_valid_r && !fuse_r)
    else $error("pin-change enabled in legacy mode");
  pcint_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && !fuse_r && in_ext && pcm_hit |=> pin_change_reg_sel_r)
    else $error("pin-change register not selected");
  timer2_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      second_wide_timer_sel_r || feature_r.second_timer_en |-> !fuse_r)
    else $error("second timer reachable in legacy mode");
  timer2_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && !fuse_r && in_ext && t2_hit |=> second_wide_timer_sel_r)
    else $error("second timer register not selected");
  timer1_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
      first_wide_timer_only_r |-> fuse_valid_r && fuse_r && !feature_r.second_timer_en)
    else $error("first timer only flag wrong");
  baud_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && cpu_req.is_io_instr
      && data_addr == SERIAL1_BAUD_HIGH_ADDR |=> serial1_baud_high_sel_r)
    else $error("serial1 baud high not selected");
  baud0_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && cpu_req.valid && fuse_ok && in_low
      && data_addr == SERIAL0_BAUD_HIGH_ADDR |=> serial0_baud_high_sel_r)
    else $error("serial0 baud high not selected");
  // Sampled reset in the antecedent; disable iff only sees the live level
  pre_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rst_n && ce && cpu_req.valid && !fuse_ok |=> unmapped_r && target_r == TGT_NONE)
    else $error("request before capture was decoded");
  // Mode outputs may only move across a reset
  mode_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
      fuse_valid_r && $past(fuse_valid_r) |-> $stable(feature_r) && $stable(vector_count_r))
    else $error("mode changed while running");
  // Clock enable low freezes every register
  freeze_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rst_n && !ce |=> $stable(target_r) && $stable(dec_r) && $stable(feature_r)
      && $stable(vector_count_r) && $stable(unmapped_r))
    else $error("state moved while clock enable low");

  ext_io_c: cover property (@(posedge mclk) dec_r.ext_io_sel);
  ext_ram_c: cover property (@(posedge mclk) target_r == TGT_EXT_RAM);
  baud0_c: cover property (@(posedge mclk) serial0_baud_high_sel_r);
  legacy_c: cover property (@(posedge mclk) first_wide_timer_only_r);
  dropped_c: cover property (@(posedge mclk) unmapped_r);
endmodule

// ---- test/cpu_core_model.sv ----
`timescale 1ns/1ps

module cpu_core_model
  import compat_map_pkg::*;
(
  input wire logic go,
  input wire logic io,
  input wire logic wr,
  input wire logic [15:0] addr,
  output cpu_req_t cpu_req
);
  // Idle bus shows the inverted address, never a stale copy
  assign cpu_req = '{valid: go, is_io_instr: io, write: wr, addr: go ? addr : ~addr};
endmodule

// ---- test/legacy_compat_io_map_tb.sv ----
`timescale 1ns/1ps

module legacy_compat_io_map_tb;
  import compat_map_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fuse = 1'b0;
  logic ce = 1'b1;
  logic go = 1'b0;
  logic io = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  cpu_req_t cpu_req;
  decode_t dec_r;
  target_t target_r;
  feature_t feature_r;
  logic [7:0] vector_count_r;
  logic s0, s1, pc, t2, t1only, fv, unm;
  int errors = 0;
  int total_checks = 0;

  cpu_core_model u_cpu_core_model (.go(go), .io(io), .wr(wr), .addr(addr), .cpu_req(cpu_req));
  legacy_compat_io_map u_legacy_compat_io_map (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .legacy_compat_fuse(fuse), .cpu_req(cpu_req), .dec_r(dec_r), .target_r(target_r),
    .feature_r(feature_r), .vector_count_r(vector_count_r), .serial0_baud_high_sel_r(s0),
    .serial1_baud_high_sel_r(s1), .pin_change_reg_sel_r(pc), .second_wide_timer_sel_r(t2),
    .first_wide_timer_only_r(t1only), .fuse_valid_r(fv), .unmapped_r(unm));

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Mode features, vector count and first timer only flag must match the fuse
  task automatic mode_check(input logic f);
    chk(feature_r === (f ? 5'b0_0000 : 5'b1_1111), "feature set");
    chk(vector_count_r === (f ? 8'h14 : 8'h1C), "vector count");
    chk(t1only === f, "first timer only flag");
  endtask

  task automatic wait_capture(input logic f);
    int n;
    n = 0;
    while (fv !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (fv !== 1'b1) begin
      errors++;
      complete_run();
    end
    #1 mode_check(f);
  endtask

  task automatic start(input logic f);
    @(posedge mclk);
    fuse <= f;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wait_capture(f);
  endtask

  // Request driven at one edge, decode seen just after the next
  task automatic acc(input logic i, input logic w, input logic [15:0] a, input target_t et,
                     input logic [15:0] ea, input logic [2:0] fl, input logic [3:0] sel);
    @(posedge mclk);
    go <= 1'b1;
    io <= i;
    wr <= w;
    addr <= a;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    chk(target_r === et && dec_r.addr === ea && dec_r.write === w, "target or address");
    chk({dec_r.ext_io_sel, dec_r.low_io_sel, dec_r.ram_sel} === fl && unm === 1'b0, "selects");
    chk({s0, s1, pc, t2} === sel, "register selects");
  endtask

  task automatic map_check(input logic f);
    acc(1'b0, 1'b0, 16'h0080, f ? TGT_EXT_RAM : TGT_EXT_IO, 16'h0080,
        f ? 3'b001 : 3'b100, {3'b000, ~f});
    acc(1'b0, 1'b1, 16'h006B, f ? TGT_EXT_RAM : TGT_EXT_IO, 16'h006B,
        f ? 3'b001 : 3'b100, {2'b00, ~f, 1'b0});
    acc(1'b0, 1'b0, 16'h00FF, f ? TGT_EXT_RAM : TGT_EXT_IO, 16'h00FF,
        f ? 3'b001 : 3'b100, 4'b0000);
    acc(1'b0, 1'b0, 16'h007C, f ? TGT_EXT_RAM : TGT_EXT_IO, 16'h007C,
        f ? 3'b001 : 3'b100, {3'b000, ~f});
    acc(1'b1, 1'b0, 16'h00BC, TGT_LOW_IO, 16'h005C, 3'b010, 4'b0100);
    acc(1'b1, 1'b1, 16'h0020, TGT_LOW_IO, 16'h0040, 3'b010, 4'b1000);
    acc(1'b1, 1'b0, 16'h003C, TGT_LOW_IO, 16'h005C, 3'b010, 4'b0100);
    acc(1'b0, 1'b0, 16'h005C, TGT_LOW_IO, 16'h005C, 3'b010, 4'b0100);
    acc(1'b0, 1'b1, 16'h0100, TGT_RAM, 16'h0100, 3'b001, 4'b0000);
  endtask

  // Fuse pin moved mid-run must not disturb the captured mode
  task automatic hold_check(input logic f);
    @(posedge mclk);
    fuse <= ~f;
    repeat (6) @(posedge mclk);
    #1 mode_check(f);
    acc(1'b0, 1'b0, 16'h0080, f ? TGT_EXT_RAM : TGT_EXT_IO, 16'h0080,
        f ? 3'b001 : 3'b100, {3'b000, ~f});
  endtask

  // Clock enable low must hold target, address, write, timer select and drop flag, whatever the request does
  task automatic freeze_check(input logic f);
    @(posedge mclk);
    go <= 1'b1;
    io <= 1'b0;
    wr <= 1'b1;
    addr <= 16'h0100;
    @(posedge mclk);
    ce <= 1'b0;
    wr <= 1'b0;
    addr <= 16'h0080;
    repeat (3) @(posedge mclk);
    #1;
    chk(target_r === TGT_RAM && dec_r.addr === 16'h0100, "frozen decode");
    chk(dec_r.write === 1'b1 && t2 === 1'b0 && unm === 1'b0, "frozen selects");
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    chk(target_r === (f ? TGT_EXT_RAM : TGT_EXT_IO) && t2 === ~f, "after freeze");
    mode_check(f);
  endtask

  // Requests ahead of fuse capture are dropped, never decoded
  task automatic refuse_check(input logic f);
    @(posedge mclk);
    fuse <= f;
    rst_n <= 1'b0;
    go <= 1'b1;
    io <= 1'b0;
    wr <= 1'b0;
    addr <= 16'h0080;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    chk(unm === 1'b1 && target_r === TGT_NONE && t2 === 1'b0, "early request");
    wait_capture(f);
  endtask

  initial begin
    start(1'b0);
    map_check(1'b0);
    freeze_check(1'b0);
    hold_check(1'b0);
    start(1'b1);
    map_check(1'b1);
    freeze_check(1'b1);
    hold_check(1'b1);
    refuse_check(1'b0);
    complete_run();
  end
endmodule
